/* File: logic/rcps_seq.sv */
// power-up sequencer and pad state control
// What this block does
// - shutdown low keeps device in low power with all logic reset
// - rts driven low within 100 ms of shutdown release
// - all pads hi-z with pull enabled during shutdown and power-up
// - with io supply and shutdown, pads three-state with pull
// - only slow clock and audio pads tolerate unpowered drive
// - active mode: tx high and rts low, inputs pulled, audio out hi-z
// - internal pulldown keeps shutdown asserted when floating
// - shutdown asserted when driven low, pulled low or floating
`timescale 1ns/1ps
module rcps_seq #(
  parameter int unsigned PWRUP_CYC = rcps_pkg::PWRUP_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              device_off_n,
  input  wire logic              device_off_n_oe,
  input  wire logic              io_supply_ok,
  output rcps_pkg::rcps_pad_t    host_link_tx,
  output rcps_pkg::rcps_pad_t    host_link_rts,
  output rcps_pkg::rcps_pad_t    host_link_rx,
  output rcps_pkg::rcps_pad_t    host_link_cts,
  output rcps_pkg::rcps_pad_t    audio_bit_clock,
  output rcps_pkg::rcps_pad_t    audio_frame_sync,
  output rcps_pkg::rcps_pad_t    audio_data_in,
  output rcps_pkg::rcps_pad_t    audio_data_out,
  output rcps_pkg::rcps_pad_t    debug_trace_out,
  output rcps_pkg::rcps_pad_t    device_off_pad,
  output logic                   io_defined,
  output rcps_pkg::rcps_state_t  power_state
);
  rcps_pkg::rcps_state_t state_q, state_d;
  logic [31:0]           cnt_q, cnt_d;
  logic                  off_req;
  logic                  active;

  // undriven pin reads low via the pulldown
  assign off_req = !(device_off_n && device_off_n_oe);
  assign device_off_pad = '{o: 1'b0, oe: 1'b0,
                            pull: rcps_pkg::PULL_DOWN};

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (off_req) begin
      state_d = rcps_pkg::RCPS_OFF;
      cnt_d   = '0;
    end else begin
      case (state_q)
        rcps_pkg::RCPS_OFF: begin
          state_d = rcps_pkg::RCPS_BOOT;
          cnt_d   = '0;
        end
        rcps_pkg::RCPS_BOOT: begin
          // fixed wait well inside the rts limit; clocks settle first
          if (cnt_q >= PWRUP_CYC - 1) begin
            state_d = rcps_pkg::RCPS_ACTIVE;
          end else begin
            cnt_d = cnt_q + 32'h0000_0001;
          end
        end
        rcps_pkg::RCPS_ACTIVE: begin
          state_d = rcps_pkg::RCPS_ACTIVE;
        end
        default: begin
          state_d = rcps_pkg::RCPS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= rcps_pkg::RCPS_OFF;
      cnt_q   <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign active      = (state_q == rcps_pkg::RCPS_ACTIVE);
  assign power_state = state_q;
  assign io_defined  = io_supply_ok;

  // pads: hi-z with pull until power-up is complete
  always_comb begin
    host_link_rx     = '{1'b0, 1'b0, rcps_pkg::PULL_UP};
    host_link_cts    = '{1'b0, 1'b0, rcps_pkg::PULL_UP};
    host_link_tx     = '{1'b0, 1'b0, rcps_pkg::PULL_UP};
    host_link_rts    = '{1'b0, 1'b0, rcps_pkg::PULL_UP};
    debug_trace_out  = '{1'b0, 1'b0, rcps_pkg::PULL_UP};
    audio_bit_clock  = '{1'b0, 1'b0, rcps_pkg::PULL_DOWN};
    audio_frame_sync = '{1'b0, 1'b0, rcps_pkg::PULL_DOWN};
    audio_data_in    = '{1'b0, 1'b0, rcps_pkg::PULL_DOWN};
    audio_data_out   = '{1'b0, 1'b0, rcps_pkg::PULL_DOWN};
    if (active) begin
      host_link_tx    = '{1'b1, 1'b1, rcps_pkg::PULL_NONE};
      // rts low marks power-up done; flow control would drive it later
      host_link_rts   = '{1'b0, 1'b1, rcps_pkg::PULL_NONE};
      debug_trace_out = '{1'b0, 1'b1, rcps_pkg::PULL_NONE};
    end
  end

  // assertions
  int unsigned rel_cnt;
  always_ff @(posedge clk) begin
    if (reset || off_req) begin
      rel_cnt <= 0;
    end else if (rel_cnt < rcps_pkg::PWRUP_MAX_CYC) begin
      rel_cnt <= rel_cnt + 1;
    end
  end

  off_holds_a: assert property (@(posedge clk) disable iff (reset)
    off_req |=> state_q == rcps_pkg::RCPS_OFF)
    else $error("device left off state while shutdown asserted");
  rts_deadline_a: assert property (@(posedge clk) disable iff (reset)
    rel_cnt >= rcps_pkg::PWRUP_MAX_CYC |-> host_link_rts.oe &&
    !host_link_rts.o)
    else $error("rts not low within power-up limit");
  pads_hiz_a: assert property (@(posedge clk) disable iff (reset)
    !active |-> !host_link_tx.oe && !host_link_rts.oe &&
    !audio_data_out.oe && host_link_rts.pull == rcps_pkg::PULL_UP)
    else $error("pad driven before power-up complete");
  audio_out_a: assert property (@(posedge clk) disable iff (reset)
    !audio_data_out.oe && audio_data_out.pull == rcps_pkg::PULL_DOWN)
    else $error("audio out not hi-z with pulldown");
  tx_high_a: assert property (@(posedge clk) disable iff (reset)
    active |-> host_link_tx.oe && host_link_tx.o &&
    host_link_cts.pull == rcps_pkg::PULL_UP)
    else $error("tx not high in active mode");
  float_off_a: assert property (@(posedge clk) disable iff (reset)
    !device_off_n_oe |=> !active)
    else $error("floating shutdown did not hold device off");
  pulldown_a: assert property (@(posedge clk) disable iff (reset)
    device_off_pad.pull == rcps_pkg::PULL_DOWN && !device_off_pad.oe)
    else $error("shutdown pin lost its pulldown");
  boot_exit_a: assert property (@(posedge clk) disable iff (reset)
    $rose(active) |-> $past(state_q) == rcps_pkg::RCPS_BOOT)
    else $error("active entered without boot");
  io_def_a: assert property (@(posedge clk) disable iff (reset)
    io_defined == io_supply_ok)
    else $error("io defined flag mismatch");

  // io ring powered and held off: every pad three-state with a pull
  supply_off_a: assert property (@(posedge clk) disable iff (reset)
    io_supply_ok && state_q == rcps_pkg::RCPS_OFF |->
    !host_link_rx.oe && !host_link_tx.oe && !debug_trace_out.oe &&
    host_link_tx.pull != rcps_pkg::PULL_NONE &&
    audio_data_in.pull != rcps_pkg::PULL_NONE)
    else $error("off pads not three-state with pull");

  // audio pads never drive, so outside drive without power is harmless
  audio_safe_a: assert property (@(posedge clk) disable iff (reset)
    !audio_bit_clock.oe && !audio_frame_sync.oe &&
    !audio_data_in.oe && !audio_data_out.oe)
    else $error("fail-safe audio pad driven");

  // boot lasts exactly the configured number of edges
  boot_len_a: assert property (@(posedge clk) disable iff (reset)
    $rose(active) |-> $past(cnt_q) == PWRUP_CYC - 1)
    else $error("boot wait length wrong");

  // counter never runs past the wait; guards a stuck boot
  boot_cnt_a: assert property (@(posedge clk) disable iff (reset)
    state_q == rcps_pkg::RCPS_BOOT |-> cnt_q < PWRUP_CYC)
    else $error("boot counter overran");

  // release from off always starts a fresh boot
  boot_entry_a: assert property (@(posedge clk) disable iff (reset)
    state_q == rcps_pkg::RCPS_OFF && !off_req |=>
    state_q == rcps_pkg::RCPS_BOOT && cnt_q == 32'h0000_0000)
    else $error("release did not start boot");

  // active inputs stay undriven with their pulls
  in_pulls_a: assert property (@(posedge clk) disable iff (reset)
    active |-> !host_link_rx.oe && !host_link_cts.oe &&
    host_link_rx.pull == rcps_pkg::PULL_UP &&
    audio_bit_clock.pull == rcps_pkg::PULL_DOWN &&
    audio_frame_sync.pull == rcps_pkg::PULL_DOWN &&
    audio_data_in.pull == rcps_pkg::PULL_DOWN)
    else $error("active input pad state wrong");

  // shutdown drops the driven outputs on the next edge
  rts_release_a: assert property (@(posedge clk) disable iff (reset)
    off_req |=> !host_link_rts.oe && !host_link_tx.oe)
    else $error("outputs still driven after shutdown");

  // before power-up is done the input pads keep their pulls
  rx_pull_off_a: assert property (@(posedge clk) disable iff (reset)
    !active |-> !host_link_rx.oe && !host_link_cts.oe &&
    host_link_cts.pull == rcps_pkg::PULL_UP &&
    audio_bit_clock.pull == rcps_pkg::PULL_DOWN &&
    !debug_trace_out.oe)
    else $error("input pad state wrong before power-up");

  // only the three coded states ever appear
  state_legal_a: assert property (@(posedge clk) disable iff (reset)
    power_state inside {rcps_pkg::RCPS_OFF, rcps_pkg::RCPS_BOOT,
                        rcps_pkg::RCPS_ACTIVE})
    else $error("illegal power state");

  // active holds until shutdown returns
  active_stays_a: assert property (@(posedge clk) disable iff (reset)
    active && !off_req |=> active)
    else $error("active mode dropped without shutdown");

  // a floating pin releases nothing
  float_pads_a: assert property (@(posedge clk) disable iff (reset)
    !device_off_n_oe |=> !host_link_rts.oe && !host_link_tx.oe)
    else $error("floating shutdown let outputs drive");

  boot_c: cover property (@(posedge clk) $rose(active));
  reoff_c: cover property (@(posedge clk) active ##1 off_req);
  abort_c: cover property (@(posedge clk)
    state_q == rcps_pkg::RCPS_BOOT ##1 off_req);
  float_c: cover property (@(posedge clk)
    !device_off_n_oe ##1 state_q == rcps_pkg::RCPS_OFF);
  nosup_c: cover property (@(posedge clk)
    !io_supply_ok && state_q == rcps_pkg::RCPS_OFF);
endmodule : rcps_seq

/* File: logic/rcps_pkg.sv */
// shared constants and types for the radio power-up sequencer
package rcps_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned PWRUP_MS       = 100;
  localparam int unsigned PWRUP_WAIT_MS  = 50;
  localparam int unsigned PWRUP_CYC      =
    (CLK_HZ / 1000) * PWRUP_WAIT_MS;
  localparam int unsigned PWRUP_MAX_CYC  = (CLK_HZ / 1000) * PWRUP_MS;
  localparam logic [1:0]  PULL_NONE      = 2'h0;
  localparam logic [1:0]  PULL_UP        = 2'h1;
  localparam logic [1:0]  PULL_DOWN      = 2'h2;

  typedef enum logic [1:0] {
    RCPS_OFF    = 2'b00,
    RCPS_BOOT   = 2'b01,
    RCPS_ACTIVE = 2'b10
  } rcps_state_t;

  // one pad: output value, output enable, pull selection
  typedef struct packed {
    logic       o;
    logic       oe;
    logic [1:0] pull;
  } rcps_pad_t;
endpackage : rcps_pkg

/* File: tb/rcps_host.sv */
// host model: drives shutdown, supply flag, watches rts
`timescale 1ns/1ps
module rcps_host #(
  parameter int unsigned HOLD_CYC = 8,
  parameter int unsigned FAST_CYC = 12,
  parameter int unsigned SLOW_CYC = 2
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic want_on,
  input  wire logic want_float,
  input  wire logic supply_on,
  input  wire logic rts_low,
  output logic      device_off_n,
  output logic      device_off_n_oe,
  output logic      io_supply_ok,
  output logic      up_seen,
  output logic      fast_clk_ok,
  output logic      slow_clk_ok
);
  logic [7:0] held_q;
  logic [7:0] since_q;
  logic       rel_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      rel_q  <= 1'b0;
      held_q <= 8'h00;
      since_q <= 8'h00;
    end else begin
      since_q <= !rel_q ? 8'h00 :
                 (since_q == 8'hff) ? since_q : since_q + 8'h01;
      // release only after minimum hold, with supply up
      rel_q  <= want_on && supply_on && (rel_q || held_q == 8'(HOLD_CYC));
      held_q <= rel_q ? 8'h00 :
                (held_q == 8'(HOLD_CYC)) ? held_q : held_q + 8'h01;
    end
  end
  // floating pin: internal pulldown wins
  assign device_off_n    = want_float ? 1'b0 : rel_q;
  assign device_off_n_oe = !want_float;
  assign io_supply_ok    = supply_on;
  assign up_seen         = rel_q && rts_low;
  // clocks come up a few edges after release, well before rts
  assign fast_clk_ok     = rel_q && since_q >= 8'(FAST_CYC);
  assign slow_clk_ok     = rel_q && since_q >= 8'(SLOW_CYC);
endmodule : rcps_host

/* File: tb/testbench.sv */
// self-checking bench for the power-up sequencer
`timescale 1ns/1ps
module testbench;
  logic clk = 0, reset = 1, on = 0, flt = 0, sup = 1;
  logic n_off, n_oe, io_ok, up, io_def, fok, sok;
  rcps_pkg::rcps_pad_t tx, rts, rx, cts, ac, af, ai, ao, dbg, offp;
  rcps_pkg::rcps_state_t st;
  int bad_count = 0, compares = 0, cyc = 0;
  always #12.5 clk = ~clk;
  rcps_host rcps_host_inst (.clk(clk), .reset(reset), .want_on(on),
    .want_float(flt), .supply_on(sup), .rts_low(rts.oe && !rts.o),
    .device_off_n(n_off), .device_off_n_oe(n_oe), .io_supply_ok(io_ok),
    .up_seen(up), .fast_clk_ok(fok), .slow_clk_ok(sok));
  rcps_seq #(.PWRUP_CYC(20)) rcps_seq_inst (.clk(clk), .reset(reset),
    .device_off_n(n_off), .device_off_n_oe(n_oe), .io_supply_ok(io_ok),
    .host_link_tx(tx), .host_link_rts(rts), .host_link_rx(rx),
    .host_link_cts(cts), .audio_bit_clock(ac), .audio_frame_sync(af),
    .audio_data_in(ai), .audio_data_out(ao), .debug_trace_out(dbg),
    .device_off_pad(offp), .io_defined(io_def), .power_state(st));
  task chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task t_off;
    chk("state", 8'(st), 8'h00);
    chk("tx", 8'(tx[2:0]), 8'h01);
    chk("rts", 8'(rts[2:0]), 8'h01);
    chk("ain", 8'(ai[2:0]), 8'h02);
    chk("dbg", 8'(dbg[2:0]), 8'h01);
    $display("done off");
  endtask : t_off
  task t_up(int exp_n);
    int n;
    n = 0;
    @(posedge clk) on <= 1'b1;
    while (n_off !== 1'b1 && n < 50) begin step(1); n++; end
    chk("slowpre", 8'(sok), 8'h00);
    n = 0;
    while (st !== rcps_pkg::RCPS_ACTIVE && n < 60) begin step(1); n++; end
    chk("edges", 8'(n), 8'(exp_n));
    chk("tx", 8'(tx), 8'h0c);
    chk("rts", 8'(rts), 8'h04);
    chk("rx", 8'(rx[2:0]), 8'h01);
    chk("aclk", 8'(ac[2:0]), 8'h02);
    chk("aout", 8'(ao[2:0]), 8'h02);
    chk("up", 8'(up), 8'h01);
    chk("fast", 8'(fok), 8'h01);
    chk("slow", 8'(sok), 8'h01);
    $display("done up");
  endtask : t_up
  task t_abort;
    @(posedge clk) on <= 1'b0;
    repeat (12) @(posedge clk);
    on <= 1'b1;
    repeat (6) @(posedge clk);
    on <= 1'b0;
    #1;
    chk("boot", 8'(st), 8'h01);
    step(3);
    chk("abort", 8'(st), 8'h00);
    chk("rts", 8'(rts[2:0]), 8'h01);
    $display("done abort");
  endtask : t_abort
  task t_float;
    @(posedge clk) flt <= 1'b1;
    on <= 1'b1;
    step(40);
    chk("float", 8'(st), 8'h00);
    chk("tx", 8'(tx[2:0]), 8'h01);
    @(posedge clk) on <= 1'b0;
    // drop the request first so the pin never shows a stray release
    repeat (2) @(posedge clk);
    flt <= 1'b0;
    sup <= 1'b0;
    step(40);
    chk("iodef", 8'(io_def), 8'h00);
    chk("nosup", 8'(st), 8'h00);
    @(posedge clk) sup <= 1'b1;
    $display("done float");
  endtask : t_float
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    step(1);
    t_off();
    t_up(21);
    t_abort();
    t_float();
    t_up(21);
    final_report();
  end
endmodule : testbench
